// ### hw/fcs_host.sv
// Summary of operation
// - Never target the paused block meanwhile.
// - Only five commands issued during erase pause; suspend only while a program or erase runs.
// - After resumed erase, read then clear status.
// - Erase: setup, then confirm at block address.
// - Identifier read: only address bit 0 set.
// - Check ready bit before result bits.
// - Mask reserved bit 0 when polling status.
`timescale 1ns/1ps
module fcs_host
  import fcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic [fcs_pkg::FCS_ADDR_W-1:0] flash_addr,
  output logic [fcs_pkg::FCS_DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [fcs_pkg::FCS_DATA_W-1:0] flash_dq_in
);
  import fcs_pkg::*;

  fcs_state_type r_reg;
  fcs_state_type r_next;

  logic [FCS_DATA_W-1:0] dq_sync;
  logic dq_stable;
  logic cmd_wr;
  logic [3:0] new_op;
  logic hit;
  logic allowed;
  logic plan_rd;
  logic [FCS_ADDR_W-1:0] plan_addr;
  logic [FCS_DATA_W-1:0] plan_data;
  logic [7:0] op_code;
  logic [7:0] poll_sr;
  logic [1:0] after_step;
  logic after_done;

  fcs_pin_sync #(
    .WIDTH(FCS_DATA_W)
  ) u_dq_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(flash_dq_in),
    .q(dq_sync),
    .stable(dq_stable)
  );

  // Command code of the first write of each operation.
  always_comb begin
    case (r_reg.op)
      FCS_OP_READ_ARRAY: op_code = FCS_CODE_READ_ARRAY;
      FCS_OP_READ_ID: op_code = FCS_CODE_READ_ID;
      FCS_OP_READ_STATUS: op_code = FCS_CODE_READ_STATUS;
      FCS_OP_CLEAR: op_code = FCS_CODE_CLEAR;
      FCS_OP_PROGRAM: op_code = FCS_CODE_PROGRAM;
      FCS_OP_ERASE: op_code = FCS_CODE_ERASE;
      FCS_OP_SUSPEND: op_code = FCS_CODE_SUSPEND;
      FCS_OP_RESUME: op_code = FCS_CODE_RESUME;
      default: op_code = FCS_CODE_READ_ARRAY;
    endcase
  end

  // Address and data of the bus cycle for the current step.
  always_comb begin
    plan_rd = 1'b0;
    plan_addr = '0;
    plan_data = {8'h00, op_code};
    case (r_reg.step)
      FCS_STEP_SECOND: begin
        plan_addr = r_reg.addr;
        if (r_reg.op == FCS_OP_PROGRAM) begin
          plan_data = r_reg.wdata;
        end else if (r_reg.op == FCS_OP_ERASE) begin
          plan_data = {8'h00, FCS_CODE_CONFIRM};
        end else if (r_reg.op == FCS_OP_READ_ID) begin
          plan_rd = 1'b1;
          plan_addr = {{(FCS_ADDR_W-1){1'b0}}, r_reg.addr[0]};
        end else begin
          plan_rd = 1'b1;
        end
      end
      FCS_STEP_POLL: begin
        plan_rd = 1'b1;
      end
      FCS_STEP_CLEAR: begin
        plan_data = {8'h00, FCS_CODE_CLEAR};
      end
      default: begin
        plan_rd = 1'b0;
      end
    endcase
  end

  // Which step follows the cycle just finished.
  always_comb begin
    after_step = r_reg.step;
    after_done = 1'b0;
    case (r_reg.step)
      FCS_STEP_CMD: begin
        if (r_reg.op == FCS_OP_CLEAR || r_reg.op == FCS_OP_RESUME) begin
          after_done = 1'b1;
        end else if (r_reg.op == FCS_OP_SUSPEND) begin
          after_step = FCS_STEP_POLL;
        end else begin
          after_step = FCS_STEP_SECOND;
        end
      end
      FCS_STEP_SECOND: after_done = 1'b1;
      FCS_STEP_POLL: begin
        if (!r_reg.rdata[FCS_SR_READY]) begin
          after_step = FCS_STEP_POLL;
        end else if (r_reg.res_erase) begin
          after_step = FCS_STEP_CLEAR;
        end else begin
          after_done = 1'b1;
        end
      end
      default: after_done = 1'b1;
    endcase
  end

  // Status byte as the host keeps it; reserved bit never trusted.
  assign poll_sr = dq_sync[7:0] & FCS_SR_RESERVED_MASK;

  assign cmd_wr = r_reg.ahb_wr && (r_reg.ahb_adr == FCS_REG_CMD);
  assign new_op = hwdata[3:0];
  assign hit = r_reg.erase_paused &&
    (r_reg.addr[FCS_ADDR_W-1:FCS_BLOCK_LSB] == r_reg.paused_block);

  // Commands the device may receive in the present condition.
  always_comb begin
    allowed = 1'b0;
    if (r_reg.busy) begin
      allowed = 1'b0;
    end else if (r_reg.running) begin
      allowed = (new_op == FCS_OP_POLL) || (new_op == FCS_OP_SUSPEND) ||
        (new_op == FCS_OP_READ_STATUS);
    end else if (r_reg.prog_paused) begin
      allowed = (new_op == FCS_OP_READ_STATUS) ||
        (new_op == FCS_OP_READ_ID) || (new_op == FCS_OP_RESUME) ||
        ((new_op == FCS_OP_READ_ARRAY) && !hit);
    end else if (r_reg.erase_paused) begin
      allowed = (new_op == FCS_OP_READ_STATUS) ||
        (new_op == FCS_OP_READ_ID) || (new_op == FCS_OP_RESUME) ||
        (((new_op == FCS_OP_READ_ARRAY) ||
          (new_op == FCS_OP_PROGRAM)) && !hit);
    end else begin
      allowed = (new_op >= FCS_OP_READ_ARRAY) &&
        (new_op <= FCS_OP_ERASE);
    end
  end

  always_comb begin
    r_next = r_reg;

    // AHB address phase; zero wait states, registered read data.
    r_next.ahb_wr = 1'b0;
    if (hsel && hready && htrans[1]) begin
      r_next.ahb_wr = hwrite;
      r_next.ahb_adr = haddr[7:0];
      r_next.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        if (haddr[7:0] == FCS_REG_CMD) begin
          r_next.hrdata = {28'h000_0000, r_reg.op};
        end else if (haddr[7:0] == FCS_REG_ADDR) begin
          r_next.hrdata = 32'(r_reg.addr);
        end else if (haddr[7:0] == FCS_REG_WDATA) begin
          r_next.hrdata = 32'(r_reg.wdata);
        end else if (haddr[7:0] == FCS_REG_RDATA) begin
          r_next.hrdata = 32'(r_reg.rdata);
        end else if (haddr[7:0] == FCS_REG_STATUS) begin
          r_next.hrdata[FCS_ST_BUSY] = r_reg.busy;
          r_next.hrdata[FCS_ST_RUNNING] = r_reg.running;
          r_next.hrdata[FCS_ST_ERASE_PAUSED] = r_reg.erase_paused;
          r_next.hrdata[FCS_ST_PROG_PAUSED] = r_reg.prog_paused;
          r_next.hrdata[FCS_ST_REFUSED] = r_reg.refused;
          r_next.hrdata[FCS_ST_SR_LSB +: 8] = r_reg.sr;
        end else begin
          r_next.hrdata = 32'h0000_0000;
        end
      end
    end

    // AHB data phase writes.
    if (r_reg.ahb_wr) begin
      if (r_reg.ahb_adr == FCS_REG_ADDR && !r_reg.busy) begin
        r_next.addr = hwdata[FCS_ADDR_W-1:0];
      end else if (r_reg.ahb_adr == FCS_REG_WDATA && !r_reg.busy) begin
        r_next.wdata = hwdata[FCS_DATA_W-1:0];
      end else if (r_reg.ahb_adr == FCS_REG_STATUS) begin
        if (hwdata[FCS_ST_REFUSED]) begin
          r_next.refused = 1'b0;
        end
      end
    end

    // Start of an operation; a refused one sets the sticky flag.
    if (cmd_wr) begin
      if (allowed) begin
        r_next.op = new_op;
        r_next.busy = 1'b1;
        r_next.seq = SEQ_SETUP;
        r_next.cnt = FCS_SETUP_CYC - 8'h01;
        r_next.step = (new_op == FCS_OP_POLL) ? FCS_STEP_POLL : FCS_STEP_CMD;
        if (new_op == FCS_OP_ERASE) begin
          r_next.paused_block = r_reg.addr[FCS_ADDR_W-1:FCS_BLOCK_LSB];
        end
        if (new_op == FCS_OP_RESUME) begin
          // The inner suspension is always resumed first.
          r_next.running = 1'b1;
          if (r_reg.prog_paused) begin
            r_next.prog_paused = 1'b0;
          end else begin
            r_next.erase_paused = 1'b0;
            r_next.res_erase = 1'b1;
          end
        end
      end else begin
        r_next.refused = 1'b1;
      end
    end

    // Pin cycle engine; chip select drops only for the cycle itself.
    case (r_reg.seq)
      SEQ_SETUP: begin
        r_next.ce_n = 1'b0;
        r_next.cyc_rd = plan_rd;
        r_next.fl_addr = plan_addr;
        r_next.fl_dq = plan_data;
        r_next.dq_oe = !plan_rd;
        if (r_reg.cnt == 8'h00) begin
          r_next.seq = SEQ_STROBE;
          // The strobe only falls one edge after this state is entered, so
          // the full count is loaded to keep it low for every strobe cycle.
          r_next.cnt = FCS_STROBE_CYC;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      SEQ_STROBE: begin
        r_next.we_n = r_reg.cyc_rd;
        r_next.oe_n = !r_reg.cyc_rd;
        if (r_reg.cnt != 8'h00) begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end else if (!r_reg.cyc_rd || dq_stable) begin
          // A read ends only once the sampled word has settled.
          r_next.seq = SEQ_HOLD;
          r_next.cnt = FCS_HOLD_CYC - 8'h01;
          r_next.we_n = 1'b1;
          r_next.oe_n = 1'b1;
          if (r_reg.cyc_rd) begin
            r_next.rdata = dq_sync;
            if (r_reg.op == FCS_OP_READ_STATUS ||
                r_reg.step == FCS_STEP_POLL) begin
              r_next.rdata = {8'h00, poll_sr};
              r_next.sr = poll_sr;
            end
          end
        end
      end
      SEQ_HOLD: begin
        if (r_reg.cnt == 8'h00) begin
          r_next.ce_n = 1'b1;
          r_next.dq_oe = 1'b0;
          r_next.step = after_step;
          r_next.seq = after_done ? SEQ_IDLE : SEQ_SETUP;
          r_next.cnt = FCS_SETUP_CYC - 8'h01;
          if (r_reg.step == FCS_STEP_SECOND &&
              (r_reg.op == FCS_OP_PROGRAM || r_reg.op == FCS_OP_ERASE)) begin
            r_next.running = 1'b1;
          end
          if (r_reg.step == FCS_STEP_POLL && r_reg.rdata[FCS_SR_READY]) begin
            // Result bits are trusted only once ready reads set.
            r_next.running = 1'b0;
            if (r_reg.op == FCS_OP_SUSPEND) begin
              if (r_reg.rdata[FCS_SR_PROGRAM_PAUSED]) begin
                r_next.prog_paused = 1'b1;
              end else if (r_reg.rdata[FCS_SR_ERASE_PAUSED]) begin
                r_next.erase_paused = 1'b1;
              end
            end
          end
          if (r_reg.step == FCS_STEP_CLEAR) begin
            r_next.res_erase = 1'b0;
          end
          if (after_done) begin
            r_next.busy = 1'b0;
          end
        end else begin
          r_next.cnt = r_reg.cnt - 8'h01;
        end
      end
      default: begin
        r_next.ce_n = 1'b1;
        r_next.we_n = 1'b1;
        r_next.oe_n = 1'b1;
        r_next.dq_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r_reg <= '{seq: SEQ_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r_reg.hrdata;
  assign flash_ce_n = r_reg.ce_n;
  assign flash_oe_n = r_reg.oe_n;
  assign flash_we_n = r_reg.we_n;
  assign flash_addr = r_reg.fl_addr;
  assign flash_dq_out = r_reg.fl_dq;
  assign flash_dq_oe = r_reg.dq_oe;

endmodule // fcs_host

// ### hw/fcs_pkg.sv
package fcs_pkg;

  // Flash pin widths.
  localparam int FCS_ADDR_W = 22;
  localparam int FCS_DATA_W = 16;
  // Lowest word-address bit that selects a block.
  localparam int FCS_BLOCK_LSB = 15;
  localparam int FCS_BLOCK_W = FCS_ADDR_W - FCS_BLOCK_LSB;

  // Clock and pin timing.
  localparam int FCS_CLK_MHZ = 40;
  localparam int FCS_T_SETUP_NS = 25;
  localparam int FCS_T_STROBE_NS = 70;
  localparam int FCS_T_HOLD_NS = 25;
  localparam int FCS_SETUP_RAW = (FCS_T_SETUP_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam int FCS_STROBE_RAW = (FCS_T_STROBE_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam int FCS_HOLD_RAW = (FCS_T_HOLD_NS * FCS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] FCS_SETUP_CYC =
    8'(FCS_SETUP_RAW < 1 ? 1 : FCS_SETUP_RAW);
  localparam logic [7:0] FCS_STROBE_CYC =
    8'(FCS_STROBE_RAW < 1 ? 1 : FCS_STROBE_RAW);
  localparam logic [7:0] FCS_HOLD_CYC =
    8'(FCS_HOLD_RAW < 1 ? 1 : FCS_HOLD_RAW);

  // Device command codes.
  localparam logic [7:0] FCS_CODE_READ_ARRAY = 8'hff;
  localparam logic [7:0] FCS_CODE_READ_ID = 8'h90;
  localparam logic [7:0] FCS_CODE_READ_STATUS = 8'h70;
  localparam logic [7:0] FCS_CODE_CLEAR = 8'h50;
  localparam logic [7:0] FCS_CODE_PROGRAM = 8'h40;
  localparam logic [7:0] FCS_CODE_ERASE = 8'h20;
  localparam logic [7:0] FCS_CODE_CONFIRM = 8'hd0;
  localparam logic [7:0] FCS_CODE_SUSPEND = 8'hb0;
  localparam logic [7:0] FCS_CODE_RESUME = 8'hd0;

  // Operation status byte fields.
  localparam int FCS_SR_READY = 7;
  localparam int FCS_SR_ERASE_PAUSED = 6;
  localparam int FCS_SR_PROGRAM_PAUSED = 2;
  localparam logic [7:0] FCS_SR_RESERVED_MASK = 8'hfe;

  // Controller operations written to the command register.
  localparam logic [3:0] FCS_OP_READ_ARRAY = 4'h1;
  localparam logic [3:0] FCS_OP_READ_ID = 4'h2;
  localparam logic [3:0] FCS_OP_READ_STATUS = 4'h3;
  localparam logic [3:0] FCS_OP_CLEAR = 4'h4;
  localparam logic [3:0] FCS_OP_PROGRAM = 4'h5;
  localparam logic [3:0] FCS_OP_ERASE = 4'h6;
  localparam logic [3:0] FCS_OP_SUSPEND = 4'h7;
  localparam logic [3:0] FCS_OP_RESUME = 4'h8;
  localparam logic [3:0] FCS_OP_POLL = 4'h9;

  // Sequence steps.
  localparam logic [1:0] FCS_STEP_CMD = 2'h0;
  localparam logic [1:0] FCS_STEP_SECOND = 2'h1;
  localparam logic [1:0] FCS_STEP_POLL = 2'h2;
  localparam logic [1:0] FCS_STEP_CLEAR = 2'h3;

  // Register map (byte offsets).
  localparam logic [7:0] FCS_REG_CMD = 8'h00;
  localparam logic [7:0] FCS_REG_ADDR = 8'h04;
  localparam logic [7:0] FCS_REG_WDATA = 8'h08;
  localparam logic [7:0] FCS_REG_RDATA = 8'h0c;
  localparam logic [7:0] FCS_REG_STATUS = 8'h10;
  localparam int FCS_ST_BUSY = 0;
  localparam int FCS_ST_RUNNING = 1;
  localparam int FCS_ST_ERASE_PAUSED = 2;
  localparam int FCS_ST_PROG_PAUSED = 3;
  localparam int FCS_ST_REFUSED = 4;
  localparam int FCS_ST_SR_LSB = 8;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SETUP,
    SEQ_STROBE,
    SEQ_HOLD
  } fcs_seq_type;

  typedef struct packed {
    fcs_seq_type seq;
    logic [3:0] op;
    logic [1:0] step;
    logic [7:0] cnt;
    logic cyc_rd;
    logic busy;
    logic running;
    logic res_erase;
    logic erase_paused;
    logic prog_paused;
    logic refused;
    logic [FCS_BLOCK_W-1:0] paused_block;
    logic [FCS_ADDR_W-1:0] addr;
    logic [FCS_DATA_W-1:0] wdata;
    logic [FCS_DATA_W-1:0] rdata;
    logic [7:0] sr;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [FCS_ADDR_W-1:0] fl_addr;
    logic [FCS_DATA_W-1:0] fl_dq;
    logic ahb_wr;
    logic [7:0] ahb_adr;
    logic [31:0] hrdata;
  } fcs_state_type;

endpackage

// ### hw/fcs_pin_sync.sv
`timescale 1ns/1ps
module fcs_pin_sync #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic stable
);

  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // The first stage feeds only the second; the agreement check looks
  // at the later two.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign q = s3_reg;
  assign stable = (s2_reg == s3_reg);

endmodule // fcs_pin_sync

// ### verif/fcs_host_props.sv
`timescale 1ns/1ps
module fcs_host_props
  import fcs_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic [fcs_pkg::FCS_ADDR_W-1:0] flash_addr,
  input wire logic [fcs_pkg::FCS_DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe,
  input wire logic [fcs_pkg::FCS_DATA_W-1:0] flash_dq_in
);
  import fcs_pkg::*;
  logic rd_stat_reg;
  logic rd_data_reg;
  logic rd_phase;
  assign rd_phase = hsel && htrans[1] && !hwrite;
  // Marks the data phase of a read so the answer can be judged there.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_stat_reg <= 1'b0;
      rd_data_reg <= 1'b0;
    end else if (hready) begin
      rd_stat_reg <= rd_phase && haddr[7:0] == FCS_REG_STATUS;
      rd_data_reg <= rd_phase && haddr[7:0] == FCS_REG_RDATA;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  strobe_excl_a: assert property (flash_we_n || flash_oe_n)
    else $error("both strobes low");
  strobe_sel_a: assert property (!(flash_we_n && flash_oe_n) |-> !flash_ce_n)
    else $error("strobe without chip select");
  write_drive_a: assert property (!flash_we_n |-> flash_dq_oe)
    else $error("write strobe with data released");
  read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("read strobe while driving data");
  write_width_a: assert property ($fell(flash_we_n) |->
    !flash_we_n [*3] ##1 flash_we_n) else $error("write strobe length");
  write_setup_a: assert property ($fell(flash_we_n) |->
    !$past(flash_ce_n) && $stable(flash_addr)) else $error("write setup");
  write_hold_a: assert property ($rose(flash_we_n) |-> !flash_ce_n &&
    flash_dq_oe && $stable(flash_dq_out)) else $error("write hold");
  stat_mask_a: assert property (rd_stat_reg |->
    hrdata[8] == 1'b0 && hrdata[31:16] == 16'h0000)
    else $error("status read not masked");
  upper_zero_a: assert property (rd_data_reg |-> hrdata[31:16] == 16'h0000)
    else $error("read word upper bits set");
endmodule // fcs_host_props

// ### verif/fcs_flash_model.sv
`timescale 1ns/1ps
module fcs_flash_model
  import fcs_pkg::*;
#(
  // Identifier values are arbitrary.
  parameter logic [15:0] MFR_CODE = 16'h00a5,
  parameter logic [15:0] DEV_CODE = 16'h005a,
  parameter int ERASE_T = 200,
  parameter int PROG_T = 100
) (
  input wire logic clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [fcs_pkg::FCS_ADDR_W-1:0] addr,
  input wire logic [fcs_pkg::FCS_DATA_W-1:0] dq_out,
  input wire logic [1:0] fail_mode,
  output logic [fcs_pkg::FCS_DATA_W-1:0] dq_in,
  output logic viol
);
  import fcs_pkg::*;
  logic [15:0] mem [32];
  logic [15:0] rd_val, last;
  logic [7:0] sr, d;
  logic [1:0] mode, pend, err;
  logic [6:0] blk;
  logic er_act, pr_act, er_sus, pr_sus, resumed, must_clr, we_q, rdy, rd;
  int er_left, pr_left, sus_left;
  assign d = dq_out[7:0];
  assign rd = !ce_n && !oe_n;
  assign rdy = sus_left == 0 && !(pr_act ? !pr_sus : er_act && !er_sus);
  // Reserved bit 0 reads as 1 so that a host which forgets to mask it shows.
  assign sr = {rdy, er_sus, err, 1'b0, pr_sus, 2'h1};
  assign rd_val = mode == 2'h0 ? mem[{addr[15], addr[3:0]}] :
    mode == 2'h1 ? (addr[0] ? DEV_CODE : MFR_CODE) : {8'h00, sr};
  // A released bus shows the inverse of the last word, never a held copy.
  assign dq_in = rd ? rd_val : ~last;
  initial begin
    foreach (mem[i]) mem[i] = 16'hffff;
    {er_act, pr_act, er_sus, pr_sus, resumed, must_clr, viol} = '0;
    {mode, pend, err, last, blk} = '0;
    {er_left, pr_left, sus_left} = '0;
    we_q = 1'b1;
  end
  always @(posedge clk) begin
    if (rd) last = rd_val;
    if (rd && mode == 2'h1 && addr[21:1] != '0) viol = 1'b1;
    if (er_sus && addr[21:15] == blk &&
        ((rd && mode == 2'h0) || (!we_n && pend == 2'h1))) viol = 1'b1;
    if (sus_left > 0) begin
      sus_left--;
      if (sus_left == 0 && pr_act) pr_sus = 1'b1;
      else if (sus_left == 0) er_sus = 1'b1;
    end else if (pr_act && !pr_sus) begin
      pr_left--;
      if (pr_left == 0) pr_act = 1'b0;
      if (pr_left == 0) err[0] = err[0] | fail_mode[0];
    end else if (er_act && !er_sus) begin
      er_left--;
      if (er_left == 0) begin
        er_act = 1'b0;
        err[1] = err[1] | fail_mode[1];
        must_clr = resumed;
        for (int i = 0; i < 32; i++) if (i[4] == blk[0]) mem[i] = 16'hffff;
      end
    end
    // Writes land on the rising write strobe and only under chip select.
    if (we_n && !we_q && !ce_n) begin
      if (must_clr && d != 8'h50 && d != 8'h70) viol = 1'b1;
      if (er_sus && !pr_act && pend == 2'h0 &&
          !(d inside {8'hd0, 8'h40, 8'h10, 8'hff, 8'h70, 8'h90})) viol = 1'b1;
      if (pend == 2'h1) begin
        mem[{addr[15], addr[3:0]}] &= dq_out;
        pr_act = 1'b1;
        pr_left = PROG_T;
        pend = 2'h0;
      end else if (pend == 2'h2) begin
        pend = 2'h0;
        if (d == 8'hd0) begin
          er_act = 1'b1;
          er_left = ERASE_T;
          blk = addr[21:15];
          resumed = 1'b0;
        end else err = 2'h3;
      end else begin
        mode = 2'h2;
        case (d)
          8'hff: mode = 2'h0;
          8'h90: mode = 2'h1;
          8'h70: mode = 2'h2;
          8'h50: {err, must_clr} = '0;
          8'h40, 8'h10: pend = 2'h1;
          8'h20: pend = 2'h2;
          8'hb0: if (pr_act ? !pr_sus : er_act && !er_sus) sus_left = 3;
          8'hd0: begin
            if (!pr_sus && er_sus) resumed = 1'b1;
            if (pr_sus) pr_sus = 1'b0;
            else er_sus = 1'b0;
          end
          default: err = 2'h3;
        endcase
      end
    end
    we_q = we_n;
  end
endmodule // fcs_flash_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fcs_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, ce_n, oe_n, we_n;
  logic dq_oe, viol;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, fail_mode;
  logic [2:0] hsize;
  logic [FCS_ADDR_W-1:0] fl_addr;
  logic [FCS_DATA_W-1:0] dq_out, dq_in;
  int err_count, n_checks;
  fcs_host dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp, .flash_ce_n(ce_n),
    .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(fl_addr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  fcs_flash_model flash (.clk(hclk), .ce_n, .oe_n, .we_n, .addr(fl_addr),
    .dq_out, .fail_mode, .dq_in, .viol);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Busy is already set at the last edge of the command write; two more cycles pass before polling it.
  task automatic op(input logic [3:0] code);
    xfer(1'b1, FCS_REG_CMD, {28'h0, code});
    repeat (2) @(posedge hclk);
    xfer(1'b0, FCS_REG_STATUS, 32'h0);
    while (rd[FCS_ST_BUSY] !== 1'b0) xfer(1'b0, FCS_REG_STATUS, 32'h0);
  endtask
  task automatic fetch(input logic [21:0] a, input logic [3:0] c,
                       input logic [15:0] e);
    xfer(1'b1, FCS_REG_ADDR, {10'h0, a});
    op(c);
    rdchk(FCS_REG_RDATA, 32'hffffffff, {16'h0, e});
  endtask
  task automatic prog(input logic [21:0] a, input logic [15:0] w);
    xfer(1'b1, FCS_REG_ADDR, {10'h0, a});
    xfer(1'b1, FCS_REG_WDATA, {16'h0, w});
    op(FCS_OP_PROGRAM);
  endtask
  task automatic t_modes;
    xfer(1'b1, 8'h20, 32'hffffffff);
    rdchk(8'h20, 32'hffffffff, 32'h0);
    fetch(22'h3ffff0, FCS_OP_READ_ID, 16'h00a5);
    fetch(22'h000001, FCS_OP_READ_ID, 16'h005a);
    chk({31'h0, viol}, 32'h0);
  endtask
  task automatic t_program;
    prog(22'h000003, 16'h1234);
    rdchk(FCS_REG_STATUS, 32'h2, 32'h2);
    op(FCS_OP_POLL);
    rdchk(FCS_REG_STATUS, 32'hff02, 32'h8000);
    fetch(22'h000003, FCS_OP_READ_ARRAY, 16'h1234);
    fetch(22'h000003, FCS_OP_READ_STATUS, 16'h0080);
  endtask
  task automatic t_suspend;
    xfer(1'b1, FCS_REG_ADDR, 32'h8000);
    op(FCS_OP_ERASE);
    op(FCS_OP_SUSPEND);
    rdchk(FCS_REG_STATUS, 32'hff0c, 32'hc004);
    fetch(22'h000003, FCS_OP_READ_ARRAY, 16'h1234);
    prog(22'h008001, 16'h0000);
    rdchk(FCS_REG_STATUS, 32'h1f, 32'h14);
    xfer(1'b1, FCS_REG_STATUS, 32'h10);
    prog(22'h000004, 16'h00f0);
    op(FCS_OP_SUSPEND);
    rdchk(FCS_REG_STATUS, 32'hff1c, 32'hc40c);
    fetch(22'h000003, FCS_OP_READ_ARRAY, 16'h1234);
    op(FCS_OP_RESUME);
    op(FCS_OP_POLL);
    rdchk(FCS_REG_STATUS, 32'hff0e, 32'hc004);
    op(FCS_OP_RESUME);
    op(FCS_OP_POLL);
    rdchk(FCS_REG_STATUS, 32'hff0e, 32'h8000);
    fetch(22'h000004, FCS_OP_READ_ARRAY, 16'h00f0);
    chk({31'h0, viol}, 32'h0);
  endtask
  task automatic t_errors;
    fail_mode <= 2'h1;
    prog(22'h000006, 16'h0000);
    op(FCS_OP_POLL);
    rdchk(FCS_REG_STATUS, 32'hff00, 32'h9000);
    fail_mode <= 2'h0;
    fetch(22'h000000, FCS_OP_READ_STATUS, 16'h0090);
    op(FCS_OP_CLEAR);
    fetch(22'h000000, FCS_OP_READ_STATUS, 16'h0080);
    fail_mode <= 2'h2;
    op(FCS_OP_ERASE);
    op(FCS_OP_POLL);
    rdchk(FCS_REG_STATUS, 32'hff00, 32'ha000);
    fail_mode <= 2'h0;
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans, fail_mode} = '0;
    hsize = 3'h2;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_modes();
    t_program();
    t_suspend();
    t_errors();
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    stop_test();
  end
endmodule // tb_top
bind fcs_host fcs_host_props u_props (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
  .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_addr, .flash_dq_out,
  .flash_dq_oe, .flash_dq_in);
